// File: design/skip_call_core.sv
// bit-test skip and subroutine call decode and execute
// assumes combinational program memory and register file reads on core_clk
module skip_call_core
	import skip_call_pkg::*;
#(
	parameter int STACK_DEPTH = 2
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire word_t       instr_word,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic [7:0]  status_in,
	output pc_t              fetch_addr,
	output faddr_t           reg_addr,
	output pc_t              stack_top,
	output logic             nop_slot,
	output logic             skip_taken,
	output logic             call_taken
);
	// reset release
	logic [1:0] rst_sync_q;
	logic       rst_core_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= `RST_SYNC_RESET;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_core_n = rst_sync_q[1];

	// execute state
	exec_state_e state_q;
	exec_state_e state_d;
	word_t       ir_q;
	word_t       ir_d;
	pc_t         pc_q;
	pc_t         pc_d;
	faddr_t      faddr_q;
	faddr_t      faddr_d;
	logic        skip_q;
	logic        skip_d;
	logic        call_q;
	logic        call_d;
	logic        nop_q;
	logic        nop_d;

	logic        is_skip;
	logic        is_call;
	logic        bit_set;
	logic        push_en;
	logic [2:0]  bsel;

	always_comb begin
		bsel    = ir_q[`BSEL_HI:`BSEL_LO];
		bit_set = reg_rdata[bsel];
		is_skip = (state_q == ST_RUN) && (ir_q[`OPC_HI:`OPC_LO] == `OPC_SKIP_SET);
		is_call = (state_q == ST_RUN) && (ir_q[`OPC_HI:`OPC_LO] == `OPC_CALL);
		push_en = is_call;
	end

	always_comb begin
		state_d = ST_RUN;
		ir_d    = instr_word;
		faddr_d = instr_word[`FADDR_HI:`FADDR_LO];
		pc_d    = pc_q + `PC_INC;
		skip_d  = 1'b0;
		call_d  = 1'b0;
		nop_d   = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (is_skip && bit_set) begin
					state_d = ST_NOP;
					skip_d  = 1'b1;
				end else if (is_call) begin
					state_d = ST_NOP;
					call_d  = 1'b1;
					pc_d[`LIT_HI:`LIT_LO]         = ir_q[`LIT_HI:`LIT_LO];
					pc_d[`PC_PAGE_HI:`PC_PAGE_LO] = status_in[`PAGE_SRC_HI:`PAGE_SRC_LO];
					pc_d[`PC_BIT8]                = 1'b0;
				end
			end
			ST_NOP: begin
				nop_d = 1'b1;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state_q <= ST_RUN;
			ir_q    <= `WORD_NOP;
			pc_q    <= `PC_RESET;
			faddr_q <= `FADDR_RESET;
			skip_q  <= 1'b0;
			call_q  <= 1'b0;
			nop_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			ir_q    <= ir_d;
			pc_q    <= pc_d;
			faddr_q <= faddr_d;
			skip_q  <= skip_d;
			call_q  <= call_d;
			nop_q   <= nop_d;
		end
	end

	// push carries the prefetch address, the word after the call
	return_stack #(
		.DEPTH     (STACK_DEPTH)
	) u_stack (
		.core_clk  (core_clk),
		.rst_n     (rst_core_n),
		.push_en   (push_en),
		.push_data (pc_q),
		.top       (stack_top)
	);

	assign fetch_addr = pc_q;
	assign reg_addr   = faddr_q;
	assign skip_taken = skip_q;
	assign call_taken = call_q;
	assign nop_slot   = nop_q;

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_core_n);

	AST_SKIP_SET_DISCARDS: assert property (
		(state_q == ST_RUN && ir_q[`OPC_HI:`OPC_LO] == `OPC_SKIP_SET
		&& reg_rdata[ir_q[`BSEL_HI:`BSEL_LO]])
		|=> state_q == ST_NOP && skip_taken && pc_q == $past(pc_q) + `PC_INC)
		else $error("taken skip did not discard the prefetched word");

	AST_SKIP_CLEAR_CONTINUES: assert property (
		(state_q == ST_RUN && ir_q[`OPC_HI:`OPC_LO] == `OPC_SKIP_SET
		&& !reg_rdata[ir_q[`BSEL_HI:`BSEL_LO]])
		|=> state_q == ST_RUN && !skip_taken && pc_q == $past(pc_q) + `PC_INC)
		else $error("skip with clear bit did not continue");

	AST_OTHER_CONTINUES: assert property (
		(rst_core_n && state_q == ST_RUN && ir_q[`OPC_HI:`OPC_LO] != `OPC_SKIP_SET
		&& ir_q[`OPC_HI:`OPC_LO] != `OPC_CALL)
		|=> state_q == ST_RUN && !skip_taken && !call_taken
		&& fetch_addr == $past(fetch_addr) + `PC_INC)
		else $error("plain word did not continue with the next word");

	AST_ONLY_CALL_JUMPS: assert property (
		(rst_core_n && !is_call)
		|=> fetch_addr == $past(fetch_addr) + `PC_INC)
		else $error("program counter jumped without a call");

	AST_SKIP_NO_PUSH: assert property (
		(state_q == ST_RUN && ir_q[`OPC_HI:`OPC_LO] == `OPC_SKIP_SET)
		|=> $stable(stack_top))
		else $error("bit test disturbed the return stack");

	AST_REG_ADDR_FIELD: assert property (
		rst_core_n
		|=> reg_addr == $past(instr_word[`FADDR_HI:`FADDR_LO]))
		else $error("register address not taken from the word field");

	AST_NOP_SLOT_ONE_CYCLE: assert property (
		skip_taken |-> state_q == ST_NOP
		##1 (state_q == ST_RUN && nop_slot)
		##1 !nop_slot)
		else $error("discarded slot not exactly one cycle");

	AST_SLOT_NO_PUSH: assert property (
		state_q == ST_NOP
		|=> $stable(stack_top))
		else $error("discarded slot pushed onto the stack");

	AST_CALL_PUSH_ADDR: assert property (
		is_call
		|=> stack_top == $past(fetch_addr) && call_taken)
		else $error("call pushed wrong return address");

	AST_CALL_LITERAL: assert property (
		(state_q == ST_RUN && ir_q[`OPC_HI:`OPC_LO] == `OPC_CALL)
		|=> fetch_addr[`LIT_HI:`LIT_LO] == $past(ir_q[`LIT_HI:`LIT_LO]) && call_taken)
		else $error("call literal not loaded into pc low byte");

	AST_CALL_PAGE: assert property (
		is_call
		|=> fetch_addr[`PC_PAGE_HI:`PC_PAGE_LO] == $past(status_in[`PAGE_SRC_HI:`PAGE_SRC_LO]))
		else $error("call page bits not from status");

	AST_CALL_BIT8_TWO_CYCLES: assert property (
		is_call |=> !fetch_addr[`PC_BIT8] && state_q == ST_NOP
		##1 state_q == ST_RUN && fetch_addr == $past(fetch_addr) + `PC_INC)
		else $error("call did not clear pc bit 8 or take two cycles");

	AST_CALL_PULSE_ONE_CYCLE: assert property (
		call_taken
		|=> !call_taken && nop_slot)
		else $error("call marker not a single cycle");

	AST_NO_BACK_TO_BACK_SLOT: assert property (
		nop_slot
		|-> !skip_taken && !call_taken)
		else $error("discarded slot executed an instruction");

	COV_SKIP_TAKEN: cover property (skip_taken ##1 state_q == ST_RUN);
	COV_SKIP_NOT_TAKEN: cover property (is_skip && !bit_set);
	COV_CALL: cover property (call_taken ##1 (state_q == ST_RUN && nop_slot));
	COV_CALL_AFTER_CALL: cover property (call_taken ##2 call_taken);
	COV_SKIP_OVER_CALL: cover property (skip_taken && ir_q[`OPC_HI:`OPC_LO] == `OPC_CALL);
endmodule : skip_call_core

// File: design/skip_call_map.svh
// constants for the bit-test skip and call decoder
// assumes inclusion by bare name from the package; the modules only use its macros
`ifndef SKIP_CALL_MAP_SVH
`define SKIP_CALL_MAP_SVH

`define OPC_HI          11
`define OPC_LO          8
`define OPC_SKIP_SET    4'h7
`define OPC_CALL        4'h9
`define BSEL_HI         7
`define BSEL_LO         5
`define FADDR_HI        4
`define FADDR_LO        0
`define LIT_HI          7
`define LIT_LO          0
`define PAGE_SRC_HI     6
`define PAGE_SRC_LO     5
`define PC_PAGE_HI      10
`define PC_PAGE_LO      9
`define PC_BIT8         8
`define PC_RESET        11'h000
`define PC_INC          11'h001
`define WORD_NOP        12'h000
`define FADDR_RESET     5'h00
`define RST_SYNC_RESET  2'h0

`endif

// File: design/skip_call_pkg.sv
// types shared by the decoder and its return stack
// assumes skip_call_map.svh is on the include path
package skip_call_pkg;
	`include "skip_call_map.svh"

	typedef logic [11:0] word_t;
	typedef logic [10:0] pc_t;
	typedef logic [4:0]  faddr_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_NOP = 2'b10
	} exec_state_e;
endpackage : skip_call_pkg

// File: design/return_stack.sv
// circular return stack with registered top of stack
// assumes reset already synchronised to core_clk by the caller
module return_stack
	import skip_call_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic push_en,
	input  wire pc_t  push_data,
	output pc_t       top
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [PW-1:0] ONE  = PW'(1);
	localparam logic [PW-1:0] ZERO = PW'(0);

	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] wr_ptr_d;
	logic [PW-1:0] top_ptr;
	pc_t           entry_q [DEPTH];
	pc_t           top_q;
	pc_t           top_d;

	// write pointer wraps so the oldest entry is overwritten
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		if (push_en) begin
			wr_ptr_d = (wr_ptr_q == LAST) ? ZERO : wr_ptr_q + ONE;
		end
		top_ptr = (wr_ptr_q == ZERO) ? LAST : wr_ptr_q - ONE;
		top_d = push_en ? push_data : entry_q[top_ptr];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= ZERO;
			top_q    <= `PC_RESET;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			top_q    <= top_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			pc_t entry_d;
			always_comb begin
				entry_d = (push_en && wr_ptr_q == PW'(i)) ? push_data : entry_q[i];
			end
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					entry_q[i] <= `PC_RESET;
				end else begin
					entry_q[i] <= entry_d;
				end
			end
		end
	endgenerate

	assign top = top_q;

	AST_STACK_TOP_PUSHED: assert property (@(posedge core_clk) disable iff (!rst_n)
		push_en |=> top == $past(push_data))
		else $error("stack top not the pushed address");

	AST_STACK_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(push_en && wr_ptr_q == LAST) |=> wr_ptr_q == ZERO)
		else $error("stack pointer did not wrap onto the oldest entry");
endmodule : return_stack

// File: tb/bit_test_skip_and_call_bench.sv
// bench for skip_call_core: runs a short program through skip and call decode
// assumes combinational program memory and register file, modelled here
module bit_test_skip_and_call_bench import skip_call_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk   = 1'b0;
	logic        rst_n      = 1'b0;
	word_t       instr_word = 12'h000;
	logic [7:0]  reg_rdata  = 8'h00;
	logic [7:0]  status_in  = 8'hff;
	pc_t         fetch_addr;
	faddr_t      reg_addr;
	pc_t         stack_top;
	logic        nop_slot;
	logic        skip_taken;
	logic        call_taken;
	word_t       prog [0:2047];
	logic [7:0]  regs [0:31];
	int          fails     = 0;
	int          tests_run = 0;

	skip_call_core #(.STACK_DEPTH(2)) u_skip_call_core (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.instr_word (instr_word),
		.reg_rdata  (reg_rdata),
		.status_in  (status_in),
		.fetch_addr (fetch_addr),
		.reg_addr   (reg_addr),
		.stack_top  (stack_top),
		.nop_slot   (nop_slot),
		.skip_taken (skip_taken),
		.call_taken (call_taken)
	);

	always #5 core_clk = ~core_clk;

	// memories answer at the falling edge
	always @(negedge core_clk) begin
		instr_word <= prog[fetch_addr];
		reg_rdata  <= regs[reg_addr];
	end

	task automatic results();
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic step(input pc_t pc, input logic sk, input logic ca, input logic np);
		@(negedge core_clk);
		chk(fetch_addr, pc);
		chk({10'h000, skip_taken}, {10'h000, sk});
		chk({10'h000, call_taken}, {10'h000, ca});
		chk({10'h000, nop_slot}, {10'h000, np});
	endtask : step

	task automatic t_reset();
		repeat (12) @(negedge core_clk);
		chk(fetch_addr, 11'h000);
		chk(stack_top, 11'h000);
		rst_n = 1'b1;
		$display("test reset done");
	endtask : t_reset

	task automatic t_skip();
		int i;
		for (i = 0; i < 20; i++) begin
			@(negedge core_clk);
			if (fetch_addr === 11'h001)
				break;
		end
		if (i == 20) begin
			fails++;
			$display("MISMATCH t=%0t no fetch after reset", $time);
			results();
		end
		chk({6'h00, reg_addr}, 11'h003);
		step(11'h002, 1'b1, 1'b0, 1'b0);
		step(11'h003, 1'b0, 1'b0, 1'b1);
		step(11'h004, 1'b0, 1'b0, 1'b0);
		$display("test skip done");
	endtask : t_skip

	task automatic t_call();
		step(11'h005, 1'b0, 1'b0, 1'b0);
		chk(stack_top, 11'h000);
		step(11'h65a, 1'b0, 1'b1, 1'b0);
		chk(stack_top, 11'h005);
		status_in = 8'h9f;
		step(11'h65b, 1'b0, 1'b0, 1'b1);
		step(11'h010, 1'b0, 1'b1, 1'b0);
		chk(stack_top, 11'h65b);
		$display("test call done");
	endtask : t_call

	task automatic t_back();
		step(11'h011, 1'b0, 1'b0, 1'b1);
		chk({6'h00, reg_addr}, 11'h01f);
		step(11'h012, 1'b1, 1'b0, 1'b0);
		step(11'h013, 1'b0, 1'b0, 1'b1);
		chk(stack_top, 11'h65b);
		$display("test back to back done");
	endtask : t_back

	task automatic t_page();
		int i;
		for (i = 0; i < 300; i++) begin
			@(negedge core_clk);
			if (fetch_addr === 11'h101)
				break;
		end
		if (i == 300) begin
			fails++;
			$display("MISMATCH t=%0t no fetch of word 101", $time);
			results();
		end
		step(11'h0c4, 1'b0, 1'b1, 1'b0);
		chk(stack_top, 11'h101);
		step(11'h0c5, 1'b0, 1'b0, 1'b1);
		$display("test page bit8 done");
	endtask : t_page

	initial begin
		for (int a = 0; a < 2048; a++)
			prog[a] = 12'h000;
		for (int r = 0; r < 32; r++)
			regs[r] = 8'h00;
		prog[0]      = 12'h7a3;
		prog[1]      = 12'h9ff;
		prog[2]      = 12'h704;
		prog[4]      = 12'h95a;
		prog[5]      = 12'h7a3;
		prog[11'h65a] = 12'h910;
		prog[11'h65b] = 12'h9ff;
		prog[11'h010] = 12'h7ff;
		prog[11'h011] = 12'h9ff;
		prog[11'h100] = 12'h9c4;
		regs[3]      = 8'h20;
		regs[4]      = 8'hfe;
		regs[31]     = 8'h80;
		t_reset();
		t_skip();
		t_call();
		t_back();
		t_page();
		results();
	end
endmodule : bit_test_skip_and_call_bench
